// ---- rtcw_pkg.sv ----
// Package with register map, field layout, reset values and helpers of the week clock.
package rtcw_pkg;

	// Register indices; the byte address on the port is four times the index.
	localparam logic [9:0] IDX_SECONDS  = 10'h118;
	localparam logic [9:0] IDX_MINUTES  = 10'h119;
	localparam logic [9:0] IDX_HOURS    = 10'h11a;
	localparam logic [9:0] IDX_WEEKDAY  = 10'h11b;
	localparam logic [9:0] IDX_CTRL1    = 10'h11c;
	localparam logic [9:0] IDX_IRQ_SEL  = 10'h11d;

	// Field positions in the time and control registers.
	localparam int BIT_BUSY         = 7;
	localparam int BIT_HOUR_FORMAT  = 6;
	localparam int BIT_AFTERNOON    = 5;
	localparam int BIT_COUNTER_RST  = 4;
	localparam int BIT_REQ_TIMING   = 3;
	localparam int BIT_RUN_STATUS   = 1;
	localparam int BIT_RUN_REQUEST  = 7;

	// Enable bit positions in the periodic interrupt select register.
	localparam int IRQ_SECOND = 0;
	localparam int IRQ_MINUTE = 1;
	localparam int IRQ_HOUR   = 2;
	localparam int IRQ_DAY    = 3;
	localparam int IRQ_WEEK   = 4;

	// Reset values.
	localparam logic [7:0] RST_TIME_REG = 8'h00;
	localparam logic [4:0] RST_IRQ_SEL  = 5'h00;
	localparam logic [7:0] RST_CNT8     = 8'h00;
	localparam logic [3:0] RST_CNT4     = 4'h0;

	// Counting limits.
	localparam logic [7:0] LAST_SEC_MIN = 8'h59;
	localparam logic [7:0] LAST_HOUR_24 = 8'h23;
	localparam logic [7:0] LAST_HOUR_12 = 8'h11;
	localparam logic [2:0] DAY_SUNDAY   = 3'h0;
	localparam logic [2:0] DAY_SATURDAY = 3'h6;
	localparam logic [3:0] BCD_NINE     = 4'h9;

	// Count-source ticks the run status needs to follow the run request.
	localparam int RUN_FOLLOW_TICKS = 2;

	// Prescaler widths and the busy window (top nibble of the 8-bit counter).
	localparam int CNT4_W = 4;
	localparam int CNT8_W = 8;
	localparam logic [3:0] BUSY_TOP_NIBBLE = 4'hf;

	typedef struct packed {
		logic [6:0] sec;
		logic [6:0] min;
		logic [5:0] hour;
		logic [2:0] wk;
	} rtcw_time_t;

	typedef struct packed {
		logic       wrap;
		logic [7:0] value;
	} rtcw_step_t;

	// Steps a two-digit BCD value, wrapping to zero after the given last value.
	function automatic rtcw_step_t rtcw_bcd_step(input logic [7:0] v, input logic [7:0] last);
		rtcw_step_t r;
		r = '{wrap: 1'b0, value: 8'h00};
		if (v == last) begin
			r.wrap = 1'b1;
		end else if (v[3:0] == BCD_NINE) begin
			r.value = {v[7:4] + 4'h1, 4'h0};
		end else begin
			r.value = {v[7:4], v[3:0] + 4'h1};
		end
		return r;
	endfunction

endpackage

// ---- rtcw_prescaler.sv ----
// Divide-by-two stage, 4-bit and 8-bit counters making the one-second tick.
`timescale 1ns/1ps
module rtcw_prescaler import rtcw_pkg::*; (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Control
	input  wire logic clear,
	input  wire logic run,
	input  wire logic src_tick,
	// Results
	output logic      sec_tick,
	output logic      busy_window
);

	logic              div2_q, div2_d;
	logic [CNT4_W-1:0] cnt4_q, cnt4_d;
	logic [CNT8_W-1:0] cnt8_q, cnt8_d;
	logic              step;

	assign step = run & src_tick;

	always_comb begin
		div2_d   = div2_q;
		cnt4_d   = cnt4_q;
		cnt8_d   = cnt8_q;
		sec_tick = 1'b0;
		if (clear) begin
			div2_d = 1'b0;
			cnt4_d = RST_CNT4;
			cnt8_d = RST_CNT8;
		end else if (step) begin
			div2_d = ~div2_q;
			if (div2_q) begin
				cnt4_d = cnt4_q + 4'h1;
				if (&cnt4_q) begin
					cnt8_d   = cnt8_q + 8'h01;
					sec_tick = &cnt8_q;
				end
			end
		end
	end

	// The last sixteenth of each second is flagged so software can avoid torn reads.
	assign busy_window = run & (cnt8_q[7:4] == BUSY_TOP_NIBBLE);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div2_q <= 1'b0;
			cnt4_q <= RST_CNT4;
			cnt8_q <= RST_CNT8;
		end else begin
			div2_q <= div2_d;
			cnt4_q <= cnt4_d;
			cnt8_q <= cnt8_d;
		end
	end

endmodule

// ---- rtcw_run_follow.sv ----
// Run status follower: copies the run request after two count-source ticks.
`timescale 1ns/1ps
module rtcw_run_follow import rtcw_pkg::*; (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Control
	input  wire logic clear,
	input  wire logic src_tick,
	input  wire logic run_request,
	// Status
	output logic      run_status
);

	logic [RUN_FOLLOW_TICKS-1:0] stage_q, stage_d;

	always_comb begin
		stage_d = stage_q;
		if (clear) begin
			stage_d = '0;
		end else if (src_tick) begin
			stage_d = {stage_q[RUN_FOLLOW_TICKS-2:0], run_request};
		end
	end

	assign run_status = stage_q[RUN_FOLLOW_TICKS-1];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage_q <= '0;
		end else begin
			stage_q <= stage_d;
		end
	end

endmodule

// ---- rtcw_top.sv ----
// Week clock top: register port, time counting, hour formats and periodic request.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
module rtcw_top import rtcw_pkg::*; (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Count source, one pulse per source cycle
	input  wire logic       subclock_quarter_tick,
	// Register port
	input  wire logic [11:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Status and request
	output logic             periodic_irq_req,
	output logic             count_active
);

	// Reset release through two flip-flops.
	logic rst_meta_q;
	logic rst_n;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// Control and time state.
	rtcw_time_t time_q, time_d;
	logic       start_q, start_d;
	logic       fmt24_q, fmt24_d;
	logic       pm_q, pm_d;
	logic       rstbit_q, rstbit_d;
	logic       timing_q, timing_d;
	logic [4:0] irqsel_q, irqsel_d;
	logic       irq_q, irq_d;
	logic [7:0] rdata_q, rdata_d;

	logic       run_status;
	logic       sec_tick;
	logic       busy;
	logic       clear_all;
	logic       stopped;
	logic [9:0] idx;
	logic       aligned;
	logic       wr_sec, wr_min, wr_hour, wr_wk, wr_ctrl1, wr_irq;

	// Decoded events of the current update.
	rtcw_step_t sec_step, min_step, hour_step;
	logic       day_adv;
	logic [2:0] wk_next;
	logic [4:0] events;

	// Word index and alignment of the register port address.
	assign idx     = reg_addr[11:2];
	assign aligned = (reg_addr[1:0] == 2'b00);
	// Time writes are refused until both the request and the status are clear.
	assign stopped = ~start_q & ~run_status;

	// True for a strobe aimed at the given register on an aligned byte address.
	function automatic logic reg_hit(input logic strobe, input logic [11:0] addr,
		input logic [9:0] want);
		return strobe && (addr[1:0] == 2'b00) && (addr[11:2] == want);
	endfunction

	assign wr_sec   = reg_hit(reg_wr, reg_addr, IDX_SECONDS);
	assign wr_min   = reg_hit(reg_wr, reg_addr, IDX_MINUTES);
	assign wr_hour  = reg_hit(reg_wr, reg_addr, IDX_HOURS);
	assign wr_wk    = reg_hit(reg_wr, reg_addr, IDX_WEEKDAY);
	assign wr_ctrl1 = reg_hit(reg_wr, reg_addr, IDX_CTRL1);
	assign wr_irq   = reg_hit(reg_wr, reg_addr, IDX_IRQ_SEL);

	// A 1 then 0 sequence on the counter reset bit clears the whole block.
	assign clear_all = wr_ctrl1 & rstbit_q & ~reg_wdata[BIT_COUNTER_RST];

	// Run status follows the run request on count-source ticks, not on the fast clock.
	rtcw_run_follow u_run_follow (
		.clk         (clk),
		.rst_n       (rst_n),
		.clear       (clear_all),
		.src_tick    (subclock_quarter_tick),
		.run_request (start_q),
		.run_status  (run_status)
	);

	// The prescaler counts only while the status is set, so a stop freezes the fraction.
	rtcw_prescaler u_prescaler (
		.clk         (clk),
		.rst_n       (rst_n),
		.clear       (clear_all),
		.run         (run_status),
		.src_tick    (subclock_quarter_tick),
		.sec_tick    (sec_tick),
		.busy_window (busy)
	);

	// Carry chain of the time fields.
	always_comb begin
		sec_step  = rtcw_bcd_step({1'b0, time_q.sec}, LAST_SEC_MIN);
		min_step  = rtcw_bcd_step({1'b0, time_q.min}, LAST_SEC_MIN);
		hour_step = rtcw_bcd_step({2'b00, time_q.hour},
			fmt24_q ? LAST_HOUR_24 : LAST_HOUR_12);
		// The day ends at the 24-hour wrap, or at the afternoon wrap in 12-hour format.
		day_adv = hour_step.wrap & (fmt24_q | pm_q);
		if (time_q.wk >= DAY_SATURDAY) begin
			wk_next = DAY_SUNDAY;
		end else begin
			wk_next = time_q.wk + 3'h1;
		end
		// Each source sees its own update; the week source needs a day advance onto Sunday.
		events = '0;
		if (sec_tick) begin
			events[IRQ_SECOND] = 1'b1;
			events[IRQ_MINUTE] = sec_step.wrap;
			events[IRQ_HOUR]   = sec_step.wrap & min_step.wrap;
			events[IRQ_DAY]    = sec_step.wrap & min_step.wrap & day_adv;
			events[IRQ_WEEK]   = events[IRQ_DAY] & (wk_next == DAY_SUNDAY);
		end
	end

	// Periodic request, one pulse after an enabled update; a counter reset drops it.
	always_comb begin
		irq_d = 1'b0;
		if (!clear_all) begin
			irq_d = |(events & irqsel_q);
		end
	end

	// Control bits and the request select.
	always_comb begin
		start_d  = start_q;
		fmt24_d  = fmt24_q;
		rstbit_d = rstbit_q;
		timing_d = timing_q;
		irqsel_d = irqsel_q;
		if (clear_all) begin
			start_d  = 1'b0;
			fmt24_d  = 1'b0;
			rstbit_d = 1'b0;
			timing_d = 1'b0;
			irqsel_d = RST_IRQ_SEL;
		end else begin
			if (wr_ctrl1) begin
				start_d  = reg_wdata[BIT_RUN_REQUEST];
				fmt24_d  = reg_wdata[BIT_HOUR_FORMAT];
				rstbit_d = reg_wdata[BIT_COUNTER_RST];
				timing_d = reg_wdata[BIT_REQ_TIMING];
			end
			// The select changes only while stopped, so no update sees a half-set source.
			if (stopped && wr_irq) begin
				irqsel_d = reg_wdata[4:0];
			end
		end
	end

	// Time fields and the afternoon bit, which the hour wrap toggles in 12-hour format.
	always_comb begin
		time_d = time_q;
		pm_d   = pm_q;
		if (clear_all) begin
			time_d = '0;
			pm_d   = 1'b0;
		end else begin
			// Counting and an accepted time write never meet: writes need the status clear.
			if (sec_tick) begin
				time_d.sec = sec_step.value[6:0];
				if (sec_step.wrap) begin
					time_d.min = min_step.value[6:0];
					if (min_step.wrap) begin
						time_d.hour = hour_step.value[5:0];
						if (hour_step.wrap && !fmt24_q) begin
							pm_d = ~pm_q;
						end
						if (day_adv) begin
							time_d.wk = wk_next;
						end
					end
				end
			end
			// Time registers take software values only while the clock is stopped.
			if (stopped) begin
				if (wr_sec) begin
					time_d.sec = reg_wdata[6:0];
				end
				if (wr_min) begin
					time_d.min = reg_wdata[6:0];
				end
				if (wr_hour) begin
					time_d.hour = reg_wdata[5:0];
				end
				if (wr_wk) begin
					time_d.wk = reg_wdata[2:0];
				end
			end
			// A written afternoon bit wins over a toggle in the same cycle.
			if (wr_ctrl1) begin
				pm_d = reg_wdata[BIT_AFTERNOON];
			end
		end
	end

	// Read data for the cycle after a read strobe.
	always_comb begin
		rdata_d = 8'h00;
		if (reg_rd && aligned) begin
			unique case (idx)
				IDX_SECONDS: rdata_d = {busy, time_q.sec};
				IDX_MINUTES: rdata_d = {busy, time_q.min};
				IDX_HOURS:   rdata_d = {2'b00, time_q.hour};
				IDX_WEEKDAY: rdata_d = {busy, 4'h0, time_q.wk};
				IDX_CTRL1:   rdata_d = {start_q, fmt24_q, pm_q, rstbit_q, timing_q,
					1'b0, run_status, 1'b0};
				IDX_IRQ_SEL: rdata_d = {3'b000, irqsel_q};
				default:     rdata_d = 8'h00;
			endcase
		end
	end

	// Control register group.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			start_q  <= 1'b0;
			fmt24_q  <= 1'b0;
			rstbit_q <= 1'b0;
			timing_q <= 1'b0;
			irqsel_q <= RST_IRQ_SEL;
		end else begin
			start_q  <= start_d;
			fmt24_q  <= fmt24_d;
			rstbit_q <= rstbit_d;
			timing_q <= timing_d;
			irqsel_q <= irqsel_d;
		end
	end

	// Time group.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			time_q <= '0;
			pm_q   <= 1'b0;
		end else begin
			time_q <= time_d;
			pm_q   <= pm_d;
		end
	end

	// Request pulse.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	// Read data register.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata        = rdata_q;
	assign periodic_irq_req = irq_q;
	assign count_active     = run_status;

endmodule

// ---- rtcw_checker.sv ----
// Port-level timing checker for the week clock, bound to its top module.
`timescale 1ns/1ps
module rtcw_checker import rtcw_pkg::*; (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rstn,
	// Count source and register port
	input wire logic        subclock_quarter_tick,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	// Status and request
	input wire logic        periodic_irq_req,
	input wire logic        count_active
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// Counter reset bit as last written, so a clearing write is not taken for a start.
	logic rst_armed_q;
	logic clear_wr;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_armed_q <= 1'b0;
		end else if (reg_wr && reg_addr == {IDX_CTRL1, 2'b00}) begin
			rst_armed_q <= reg_wdata[BIT_COUNTER_RST];
		end
	end

	assign clear_wr = rst_armed_q & ~reg_wdata[BIT_COUNTER_RST];

	sequence s_rd(logic [9:0] idx);
		reg_rd && reg_addr == {idx, 2'b00};
	endsequence
	sequence s_ctl_wr;
		reg_wr && reg_addr == {IDX_CTRL1, 2'b00};
	endsequence

	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not idle");
	a_rd_misaligned: assert property (reg_rd && reg_addr[1:0] != 2'b00 |=> !reg_rdata)
		else $error("misaligned read returned data");
	a_status_read: assert property (s_rd(IDX_CTRL1) |=> reg_rdata[1] == $past(count_active))
		else $error("status bit differs from run status");
	a_wk_zero_bits: assert property (s_rd(IDX_WEEKDAY) |=> reg_rdata[6:3] == 4'h0)
		else $error("weekday unused bits not zero");
	a_irq_pulse: assert property (periodic_irq_req |=> !periodic_irq_req)
		else $error("periodic request longer than one cycle");
	a_irq_running: assert property (periodic_irq_req |-> $past(count_active))
		else $error("periodic request while stopped");
	a_start_follow: assert property (s_ctl_wr ##0 (reg_wdata[7] && !clear_wr &&
		!count_active) |-> ##[1:8] count_active) else $error("run status did not rise");
	a_stop_follow: assert property (s_ctl_wr ##0 (!reg_wdata[7] && count_active)
		|-> ##[1:8] !count_active) else $error("run status did not fall");
	a_rise_on_tick: assert property ($rose(count_active) |-> $past(subclock_quarter_tick))
		else $error("run status rose without a source tick");
endmodule

bind rtcw_top rtcw_checker u_chk (.clk, .rstn, .subclock_quarter_tick, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .periodic_irq_req, .count_active);

// ---- tb_top.sv ----
// Self-checking bench for the week clock register port and time counting.
`timescale 1ns/1ps
module tb_top import rtcw_pkg::*;;
	localparam logic [11:0] A_SEC = {IDX_SECONDS, 2'b00}, A_MIN = {IDX_MINUTES, 2'b00},
		A_HR = {IDX_HOURS, 2'b00}, A_WK = {IDX_WEEKDAY, 2'b00},
		A_CTL = {IDX_CTRL1, 2'b00}, A_IRQ = {IDX_IRQ_SEL, 2'b00};
	logic        clk = 1'b0, rstn = 1'b0, tick = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [7:0]  wdata = 8'h00;
	logic [7:0]  rdata;
	logic        irq;
	logic        act;
	int          n_fail = 0, total_checks = 0, cyc = 0;

	rtcw_top dut (.clk(clk), .rstn(rstn), .subclock_quarter_tick(tick), .reg_addr(addr),
		.reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
		.periodic_irq_req(irq), .count_active(act));

	always #10 clk = ~clk;
	always @(posedge clk) tick <= ~tick;

	task automatic end_sim();
		if (n_fail == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// The five runs need about 82000 cycles.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			n_fail++;
			end_sim();
		end
	end

	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wreg(logic [11:0] a, logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rchk(logic [11:0] a, logic [7:0] exp, string what);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 check(what, rdata, exp);
	endtask

	// Presets a time while stopped, runs across one second and checks the carries.
	task automatic run(logic [7:0] c, irqs, hr, mn, sc, wk, eh, em, es, ew, ec);
		int i;
		wreg(A_CTL, c);
		wreg(A_SEC, sc);
		wreg(A_MIN, mn);
		wreg(A_HR, hr);
		wreg(A_WK, wk);
		wreg(A_IRQ, irqs);
		rchk(A_HR, hr, "hours preset");
		wreg(A_CTL, c | 8'h80);
		repeat (8) @(posedge clk);
		#1 check("run status", {7'h00, act}, 8'h01);
		repeat (16000) @(posedge clk);
		rchk(A_SEC, sc | 8'h80, "seconds busy");
		i = 0;
		while (irq !== 1'b1 && i < 1200) begin
			@(posedge clk);
			#1 i++;
		end
		check("periodic request", {7'h00, irq}, 8'h01);
		rchk(A_SEC, es, "seconds");
		rchk(A_MIN, em, "minutes");
		rchk(A_HR, eh, "hours");
		rchk(A_WK, ew, "weekday");
		rchk(A_CTL, ec, "control");
		wreg(A_SEC, 8'h30);
		rchk(A_SEC, es, "seconds while running");
		wreg(A_CTL, c);
		repeat (8) @(posedge clk);
		#1 check("stop status", {7'h00, act}, 8'h00);
	endtask

	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		rchk(A_CTL, 8'h00, "control reset");
		rchk(A_IRQ, 8'h00, "irq select reset");
		rchk(A_SEC, 8'h00, "seconds reset");
		rchk(A_WK, 8'h00, "weekday reset");
		rchk(A_SEC | 12'h001, 8'h00, "misaligned read");
		rchk(12'h47c, 8'h00, "unmapped read");
		run(8'h28, 8'h10, 8'h11, 8'h59, 8'h59, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h8a);
		run(8'h48, 8'h08, 8'h23, 8'h59, 8'h59, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'hca);
		run(8'h48, 8'h04, 8'h09, 8'h59, 8'h59, 8'h03, 8'h10, 8'h00, 8'h00, 8'h03, 8'hca);
		run(8'h08, 8'h02, 8'h11, 8'h59, 8'h59, 8'h02, 8'h00, 8'h00, 8'h00, 8'h02, 8'haa);
		run(8'h48, 8'h01, 8'h12, 8'h34, 8'h09, 8'h01, 8'h12, 8'h34, 8'h10, 8'h01, 8'hca);
		wreg(A_CTL, 8'h10);
		wreg(A_CTL, 8'h00);
		rchk(A_SEC, 8'h00, "seconds cleared");
		rchk(A_HR, 8'h00, "hours cleared");
		rchk(A_MIN, 8'h00, "minutes cleared");
		rchk(A_WK, 8'h00, "weekday cleared");
		rchk(A_IRQ, 8'h00, "irq select cleared");
		rchk(A_CTL, 8'h00, "control cleared");
		end_sim();
	end
endmodule
